/* design/cam_pkg.sv */
// shared constants, types and helpers for the camera video port
package cam_pkg;
	localparam logic [6:0] ADDR_AS_HIGH = 7'h45;
	localparam logic [6:0] ADDR_AS_LOW = 7'h46;
	localparam logic [7:0] IDX_MODE = 8'h00;
	localparam logic [7:0] IDX_RATE = 8'h01;
	localparam logic [7:0] IDX_ZONE = 8'h02;
	localparam logic [7:0] IDX_STATUS = 8'h03;
	localparam int MODE_FMT_LSB = 0;
	localparam int MODE_OSEL = 3;
	localparam int MODE_PD = 4;
	localparam int MODE_HSP = 5;
	localparam int MODE_VSP = 6;
	localparam int RATE_LSB = 0;
	localparam int RATE_PAL = 3;
	localparam logic [2:0] FMT_QCIF = 3'h3;
	localparam logic [2:0] FMT_CCIR_A = 3'h4;
	localparam logic [2:0] FMT_CCIR_B = 3'h5;
	localparam logic [10:0] CIF_WORDS = 11'h160;
	localparam logic [10:0] QCIF_WORDS = 11'h0b0;
	localparam logic [10:0] CCIR_WORDS = 11'h580;
	localparam logic [9:0] CIF_LINES = 10'h120;
	localparam logic [9:0] QCIF_LINES = 10'h090;
	localparam logic [7:0] CHROMA_NEUTRAL = 8'h80;
	localparam logic [7:0] BLANK_Y = 8'h00;
	localparam int STRAP_W = 7;
	localparam logic [6:0] STRAP_INV_MASK = 7'h3f;
	localparam int STRAP_ZONE_LSB = 0;
	localparam int STRAP_FMT = 4;
	localparam int STRAP_OSEL = 5;
	localparam int STRAP_PD = 6;
	localparam logic [10:0] H_TOTAL_NTSC_DEF = 11'h6b4;
	localparam logic [10:0] H_TOTAL_PAL_DEF = 11'h6c0;
	localparam logic [9:0] V_TOTAL_NTSC_DEF = 10'h20d;
	localparam logic [9:0] V_TOTAL_PAL_DEF = 10'h271;
	localparam logic [10:0] H_SYNC_WORDS = 11'h040;
	localparam logic [9:0] V_SYNC_LINES = 10'h003;
	localparam logic [9:0] V_ACTIVE_START = 10'h014;

	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_ADDR = 5'b00010,
		S_ACK = 5'b00100,
		S_WRITE = 5'b01000,
		S_READ = 5'b10000
	} slv_state_t;

	typedef struct packed {
		logic we;
		logic [7:0] idx;
		logic [7:0] data;
	} regwr_t;

	// frame divisor per rate step: 30, 15, 10, 7.5, 6, 5, 3, 1 fps
	function automatic logic [4:0] rate_div(input logic [2:0] step);
		logic [4:0] d;
		d = 5'h01;
		unique case (step)
			3'h0: d = 5'h01;
			3'h1: d = 5'h02;
			3'h2: d = 5'h03;
			3'h3: d = 5'h04;
			3'h4: d = 5'h05;
			3'h5: d = 5'h06;
			3'h6: d = 5'h0a;
			3'h7: d = 5'h1e;
		endcase
		return d;
	endfunction

	function automatic logic is_ccir(input logic [2:0] fmt);
		return fmt == FMT_CCIR_A || fmt == FMT_CCIR_B;
	endfunction

	function automatic logic [7:0] avg8(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[8:1];
	endfunction
endpackage

/* design/camera_port.sv */
// video output port, strap defaults and control registers of the camera
// How it works
// - luminance samples leave on the eight-bit luma output bus
// - inverted copy of the reference as pixel clock; receiver captures each word on its rising edge
// - active-low vertical sync marks each new frame
// - active-low horizontal sync marks each new line
// - over-range output follows the converter over-range flag
// - active line reference high only while picture data is out
// - bus address 100 0101 with select high, 100 0110 with it low
// - chip reset pin low forces all control registers to defaults
// - straps set format, output select, power down, zone; low six inverted
// - formats 352x288, 176x144 and 704x288
// - frame rate from thirty to one fps in eight steps
// - sixteen backlight zones selected through bus registers
// - runs unprogrammed at 25 fps PAL or 30 fps NTSC
// - eight-bit 4:2:2 output stream with neutral chroma
// - all video timing counts edges of the 27 MHz reference
// - one word on the bus per pixel clock period
// - power-down pin low enters power down
// - hsync polarity chosen by a control bit
// - vsync polarity chosen by a control bit
`timescale 1ns/1ps
module camera_port #(
	parameter logic [10:0] H_TOTAL_NTSC = cam_pkg::H_TOTAL_NTSC_DEF,
	parameter logic [10:0] H_TOTAL_PAL = cam_pkg::H_TOTAL_PAL_DEF,
	parameter logic [9:0] V_TOTAL_NTSC = cam_pkg::V_TOTAL_NTSC_DEF,
	parameter logic [9:0] V_TOTAL_PAL = cam_pkg::V_TOTAL_PAL_DEF,
	parameter logic PAL_DEFAULT = 1'b0
) (
	// system clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// reference clock and chip pins
	input wire logic REF_CLOCK_IN,
	input wire logic CHIP_RESET_N,
	input wire logic POWER_DOWN_PIN_N,
	input wire logic ADDR_SELECT,
	input wire logic [cam_pkg::STRAP_W-1:0] POWERUP_STRAP,
	// two-wire bus, open-drain data
	input wire logic SERIAL_CLOCK_PIN,
	input wire logic SERIAL_DATA_IN,
	output logic SERIAL_DATA_OUT,
	output logic SERIAL_DATA_OE_N,
	// converter samples
	input wire logic [7:0] ADC_DATA,
	input wire logic ADC_OVER,
	// video port
	output logic [7:0] LUMA_OUT,
	output logic PIXEL_CLK_OUT,
	output logic VSYNC_N,
	output logic HSYNC_N,
	output logic ACTIVE_LINE_REF,
	output logic ADC_OVER_RANGE,
	// control state
	output logic POWER_DOWN,
	output logic [3:0] BACKLIGHT_ZONE
);
	import cam_pkg::*;

	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] rate;
		logic [7:0] zone;
		logic ref_d;
		logic [2:0] boot;
		logic [10:0] hcnt;
		logic [9:0] vcnt;
		logic [4:0] fcnt;
		logic [7:0] prev;
		logic pclk;
		logic vs_n;
		logic hs_n;
		logic active_line_ref;
		logic adc_over_range;
		logic [7:0] y;
	} cam_t;

	localparam int SYNC_W = 6 + STRAP_W;

	cam_t s;
	cam_t next_s;
	logic [SYNC_W-1:0] pins;
	logic ref_s;
	logic pin_reset_n;
	logic creset;
	logic pdpin_n;
	logic asel;
	logic scl_s;
	logic sda_s;
	logic [STRAP_W-1:0] strap_v;
	logic [6:0] own_addr;
	logic [7:0] rd_idx;
	logic [7:0] rdata;
	regwr_t wr;
	logic ref_rise;
	logic pd;
	logic [2:0] fmt;
	logic pal;
	logic vsync_polarity;
	logic hsync_polarity;
	logic [10:0] h_total;
	logic [9:0] v_total;
	logic [10:0] act_w;
	logic [9:0] act_l;
	logic vs_act;
	logic hs_act;
	logic active_line_ref_c;
	logic [7:0] luma_c;

	if (H_TOTAL_NTSC <= CCIR_WORDS + H_SYNC_WORDS || H_TOTAL_PAL <= CCIR_WORDS + H_SYNC_WORDS)
		$error("line total too short for the widest format");
	if (V_TOTAL_NTSC <= V_ACTIVE_START + CIF_LINES || V_TOTAL_PAL <= V_ACTIVE_START + CIF_LINES)
		$error("frame total too short for the active lines");

	pin_sync #(
		.W(SYNC_W)
	) u_sync (
		.clk(CLK),
		.rst_n(RESETN),
		.d({REF_CLOCK_IN, CHIP_RESET_N, POWER_DOWN_PIN_N, ADDR_SELECT,
			SERIAL_CLOCK_PIN, SERIAL_DATA_IN, POWERUP_STRAP}),
		.q(pins)
	);

	assign {ref_s, pin_reset_n, pdpin_n, asel, scl_s, sda_s} = pins[SYNC_W-1:STRAP_W];
	// hold chip reset until the straps have crossed the synchroniser
	assign creset = ~pin_reset_n | ~s.boot[2];
	assign strap_v = pins[STRAP_W-1:0] ^ STRAP_INV_MASK;
	assign own_addr = asel ? ADDR_AS_HIGH : ADDR_AS_LOW;

	twowire_slave u_slave (
		.clk(CLK),
		.rst_n(RESETN),
		.hold(creset),
		.scl(scl_s),
		.sda(sda_s),
		.sda_oe_n(SERIAL_DATA_OE_N),
		.own_addr(own_addr),
		.rdata(rdata),
		.rd_idx(rd_idx),
		.wr(wr)
	);

	assign SERIAL_DATA_OUT = 1'b0;

	assign ref_rise = ref_s & ~s.ref_d;
	assign pd = s.mode[MODE_PD] | ~pdpin_n;
	assign fmt = s.mode[MODE_FMT_LSB +: 3];
	assign pal = s.rate[RATE_PAL];
	assign vsync_polarity = s.mode[MODE_VSP];
	assign hsync_polarity = s.mode[MODE_HSP];
	assign h_total = pal ? H_TOTAL_PAL : H_TOTAL_NTSC;
	assign v_total = pal ? V_TOTAL_PAL : V_TOTAL_NTSC;

	always_comb
	begin
		act_w = CIF_WORDS;
		act_l = CIF_LINES;
		if (fmt == FMT_QCIF)
		begin
			act_w = QCIF_WORDS;
			act_l = QCIF_LINES;
		end
		else if (is_ccir(fmt))
			act_w = CCIR_WORDS;
	end

	assign vs_act = s.vcnt < V_SYNC_LINES;
	assign hs_act = s.hcnt >= h_total - H_SYNC_WORDS;
	assign active_line_ref_c = s.fcnt == 5'h00 && s.hcnt < act_w && s.vcnt >= V_ACTIVE_START
		&& s.vcnt < V_ACTIVE_START + act_l;

	always_comb
	begin
		luma_c = ADC_DATA;
		if (s.mode[MODE_OSEL])
			luma_c = ADC_DATA;
		else if (is_ccir(fmt))
			luma_c = !s.hcnt[0] ? CHROMA_NEUTRAL : (s.hcnt[1] ? avg8(s.prev, ADC_DATA) : ADC_DATA);
		else if (fmt == FMT_QCIF)
			luma_c = avg8(s.prev, ADC_DATA);
	end

	always_comb
	begin
		rdata = 8'h00;
		unique case (rd_idx)
			IDX_MODE: rdata = s.mode;
			IDX_RATE: rdata = s.rate;
			IDX_ZONE: rdata = s.zone;
			IDX_STATUS: rdata = {4'h0, pd, s.adc_over_range, s.active_line_ref, ~s.vs_n ^ vsync_polarity};
			default: rdata = 8'h00;
		endcase
	end

	always_comb
	begin
		next_s = s;
		next_s.ref_d = ref_s;
		next_s.boot = {s.boot[1:0], 1'b1};
		next_s.pclk = ~ref_s;
		if (wr.we)
		begin
			unique case (wr.idx)
				IDX_MODE: next_s.mode = wr.data;
				IDX_RATE: next_s.rate = wr.data;
				IDX_ZONE: next_s.zone = {4'h0, wr.data[3:0]};
				default: ;
			endcase
		end
		if (creset)
		begin
			next_s.mode = 8'h00;
			next_s.mode[MODE_FMT_LSB] = strap_v[STRAP_FMT];
			next_s.mode[MODE_OSEL] = strap_v[STRAP_OSEL];
			next_s.mode[MODE_PD] = strap_v[STRAP_PD];
			next_s.zone = {4'h0, strap_v[STRAP_ZONE_LSB +: 4]};
			next_s.rate = 8'h00;
			next_s.rate[RATE_PAL] = PAL_DEFAULT;
			next_s.hcnt = 11'h000;
			next_s.vcnt = 10'h000;
			next_s.fcnt = 5'h00;
			next_s.active_line_ref = 1'b0;
			next_s.y = BLANK_Y;
			next_s.vs_n = 1'b1;
			next_s.hs_n = 1'b1;
		end
		else if (pd)
		begin
			// counters hold so the frame resumes where it stopped
			next_s.active_line_ref = 1'b0;
			next_s.y = BLANK_Y;
			next_s.vs_n = ~vsync_polarity;
			next_s.hs_n = ~hsync_polarity;
		end
		else if (ref_rise)
		begin
			next_s.prev = ADC_DATA;
			next_s.adc_over_range = ADC_OVER;
			next_s.active_line_ref = active_line_ref_c;
			next_s.y = active_line_ref_c ? luma_c : BLANK_Y;
			next_s.vs_n = ~vs_act ^ vsync_polarity;
			next_s.hs_n = ~hs_act ^ hsync_polarity;
			next_s.hcnt = s.hcnt + 11'h001;
			if (s.hcnt >= h_total - 11'h001)
			begin
				next_s.hcnt = 11'h000;
				next_s.vcnt = s.vcnt + 10'h001;
				if (s.vcnt >= v_total - 10'h001)
				begin
					next_s.vcnt = 10'h000;
					next_s.fcnt = s.fcnt + 5'h01;
					if (s.fcnt + 5'h01 >= rate_div(s.rate[RATE_LSB +: 3]))
						next_s.fcnt = 5'h00;
				end
			end
		end
	end

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			s <= '{mode: 8'h01, vs_n: 1'b1, hs_n: 1'b1, default: '0};
		else
			s <= next_s;
	end

	assign LUMA_OUT = s.y;
	assign PIXEL_CLK_OUT = s.pclk;
	assign VSYNC_N = s.vs_n;
	assign HSYNC_N = s.hs_n;
	assign ACTIVE_LINE_REF = s.active_line_ref;
	assign ADC_OVER_RANGE = s.adc_over_range;
	assign POWER_DOWN = pd;
	assign BACKLIGHT_ZONE = s.zone[3:0];

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	sequence tick_s;
		ref_rise && !creset && !pd;
	endsequence

	pclk_edge_a: assert property (ref_rise |=> !PIXEL_CLK_OUT)
		else $error("pixel clock not low after reference rise");
	over_range_a: assert property (tick_s |=> ADC_OVER_RANGE == $past(ADC_OVER))
		else $error("over-range does not follow converter");
	luma_blank_a: assert property (!ACTIVE_LINE_REF |-> LUMA_OUT == BLANK_Y)
		else $error("luma not blank outside active line");
	active_line_ref_skip_a: assert property (tick_s ##0 s.fcnt != 5'h00 |=> !ACTIVE_LINE_REF)
		else $error("picture in a skipped frame");
	vsync_pol_a: assert property (tick_s |=> VSYNC_N == ($past(vs_act) ^~ $past(vsync_polarity)))
		else $error("vsync level or polarity wrong");
	hsync_pol_a: assert property (tick_s |=> HSYNC_N == ($past(hs_act) ^~ $past(hsync_polarity)))
		else $error("hsync level or polarity wrong");
	strap_load_a: assert property (creset |=> BACKLIGHT_ZONE == $past(strap_v[3:0]))
		else $error("zone default not taken from straps");
	pd_hold_a: assert property (pd && !creset |=> $stable(s.hcnt) && !ACTIVE_LINE_REF)
		else $error("timing advanced in power down");
	chroma_word_a: assert property (tick_s ##0 (active_line_ref_c && is_ccir(fmt) && !s.mode[MODE_OSEL]
		&& !s.hcnt[0]) |=> LUMA_OUT == CHROMA_NEUTRAL)
		else $error("chroma word not neutral");
	rate_reset_a: assert property (creset |=> s.rate[2:0] == 3'h0)
		else $error("frame rate default not full rate");
endmodule

/* design/pin_sync.sv */
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// raw and synchronised levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_t;
	sync_t s;
	sync_t next_s;

	if (W < 1)
		$error("pin_sync width must be at least one");

	always_comb
	begin
		next_s.s1 = d;
		next_s.s2 = s.s1;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s <= '0;
		else
			s <= next_s;
	end

	assign q = s.s2;
endmodule

/* design/twowire_slave.sv */
// two-wire bus slave with register index pointer
`timescale 1ns/1ps
module twowire_slave (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hold,
	// synchronised bus lines and open-drain data drive
	input wire logic scl,
	input wire logic sda,
	output logic sda_oe_n,
	// register side
	input wire logic [6:0] own_addr,
	input wire logic [7:0] rdata,
	output logic [7:0] rd_idx,
	output cam_pkg::regwr_t wr
);
	import cam_pkg::*;

	typedef struct packed {
		slv_state_t st;
		logic scl_d;
		logic sda_d;
		logic [3:0] bitc;
		logic [7:0] sh;
		logic rw;
		logic have_idx;
		logic [7:0] idx;
		logic drive;
		regwr_t wr;
	} slv_t;
	slv_t s;
	slv_t next_s;
	logic rise;
	logic fall;
	logic start;
	logic stop;

	assign rise = scl & ~s.scl_d;
	assign fall = ~scl & s.scl_d;
	assign start = scl & s.scl_d & s.sda_d & ~sda;
	assign stop = scl & s.scl_d & ~s.sda_d & sda;

	always_comb
	begin
		next_s = s;
		next_s.scl_d = scl;
		next_s.sda_d = sda;
		next_s.wr.we = 1'b0;
		if (hold || stop)
		begin
			next_s.st = S_IDLE;
			next_s.drive = 1'b0;
		end
		else if (start)
		begin
			next_s.st = S_ADDR;
			next_s.bitc = 4'h0;
			next_s.drive = 1'b0;
		end
		else if (rise)
		begin
			unique case (s.st)
				S_ADDR, S_WRITE:
				begin
					next_s.sh = {s.sh[6:0], sda};
					next_s.bitc = s.bitc + 4'h1;
				end
				S_READ:
				begin
					if (s.bitc != 4'h8)
						next_s.bitc = s.bitc + 4'h1;
					else if (sda)
						next_s.st = S_IDLE;
					else
					begin
						next_s.bitc = 4'h9;
						next_s.idx = s.idx + 8'h01;
					end
				end
				S_IDLE, S_ACK: ;
				default: next_s.st = S_IDLE;
			endcase
		end
		else if (fall)
		begin
			unique case (s.st)
				S_ADDR:
				begin
					if (s.bitc == 4'h8 && s.sh[7:1] == own_addr)
					begin
						next_s.drive = 1'b1;
						next_s.rw = s.sh[0];
						next_s.have_idx = s.have_idx & s.sh[0];
						next_s.st = S_ACK;
					end
					else if (s.bitc == 4'h8)
						next_s.st = S_IDLE;
				end
				S_WRITE:
				begin
					if (s.bitc == 4'h8)
					begin
						next_s.drive = 1'b1;
						next_s.st = S_ACK;
						if (!s.have_idx)
						begin
							next_s.idx = s.sh;
							next_s.have_idx = 1'b1;
						end
						else
						begin
							next_s.wr = '{we: 1'b1, idx: s.idx, data: s.sh};
							next_s.idx = s.idx + 8'h01;
						end
					end
				end
				S_ACK:
				begin
					next_s.bitc = 4'h0;
					next_s.st = s.rw ? S_READ : S_WRITE;
					next_s.sh = rdata;
					next_s.drive = s.rw & ~rdata[7];
				end
				S_READ:
				begin
					if (s.bitc == 4'h9)
					begin
						next_s.bitc = 4'h0;
						next_s.sh = rdata;
						next_s.drive = ~rdata[7];
					end
					else if (s.bitc == 4'h8)
						next_s.drive = 1'b0;
					else
					begin
						next_s.drive = ~s.sh[6];
						next_s.sh = {s.sh[6:0], 1'b0};
					end
				end
				S_IDLE: ;
				default: next_s.st = S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s <= '{st: S_IDLE, scl_d: 1'b1, sda_d: 1'b1, default: '0};
		else
			s <= next_s;
	end

	assign sda_oe_n = ~s.drive;
	assign rd_idx = s.idx;
	assign wr = s.wr;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	foreign_addr_a: assert property (
		(s.st == S_ADDR && fall && !start && !stop && !hold && s.bitc == 4'h8
			&& s.sh[7:1] != own_addr) |=> sda_oe_n && s.st == S_IDLE)
		else $error("slave acknowledged a foreign address");
	write_pulse_a: assert property (
		wr.we |-> s.st == S_ACK && s.have_idx ##1 !wr.we)
		else $error("register write pulse malformed");
endmodule

/* tb/tb_camera_port.sv */
// self-checking bench of the camera video port
`timescale 1ns/1ps
module tb_camera_port;
	import cam_pkg::*;
	logic clk, resetn, ref_clk, chip_reset_n, pd_pin_n, addr_sel;
	logic [STRAP_W-1:0] strap;
	logic scl, sda_low, sda, sda_out, sda_oe_n, adc_over, pclk, vsync_n, hsync_n, active_line_ref, adc_over_range;
	logic power_down, ack;
	logic [7:0] adc_data, luma, rd;
	logic [3:0] zone, zone_def;
	int n_mismatch;
	int n_checks;

	// open-drain wire with pull-up
	assign sda = ~(sda_low | ~sda_oe_n);
	assign zone_def = 4'(strap ^ STRAP_INV_MASK);

	// shortest line and frame the design accepts
	camera_port #(.H_TOTAL_NTSC(11'h5c1), .V_TOTAL_NTSC(10'h135)) dut (
		.CLK(clk), .RESETN(resetn), .REF_CLOCK_IN(ref_clk), .CHIP_RESET_N(chip_reset_n),
		.POWER_DOWN_PIN_N(pd_pin_n), .ADDR_SELECT(addr_sel), .POWERUP_STRAP(strap),
		.SERIAL_CLOCK_PIN(scl), .SERIAL_DATA_IN(sda), .SERIAL_DATA_OUT(sda_out),
		.SERIAL_DATA_OE_N(sda_oe_n), .ADC_DATA(adc_data), .ADC_OVER(adc_over),
		.LUMA_OUT(luma), .PIXEL_CLK_OUT(pclk), .VSYNC_N(vsync_n), .HSYNC_N(hsync_n),
		.ACTIVE_LINE_REF(active_line_ref), .ADC_OVER_RANGE(adc_over_range), .POWER_DOWN(power_down),
		.BACKLIGHT_ZONE(zone)
	);

	video_host host (
		.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda), .pclk(pclk), .hsync_n(hsync_n)
	);

	always #2 clk = ~clk;

	// reference phase unrelated to the system clock
	initial
	begin
		ref_clk = 1'b0;
		#1.3;
		forever #24 ref_clk = ~ref_clk;
	end

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task wait_clk(input int n);
		repeat (n) @(negedge clk);
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task t_reset;
		check("luma in reset", luma, 8'h00);
		check("vsync in reset", vsync_n, 1'b1);
		check("hsync in reset", hsync_n, 1'b1);
		check("active_line_ref in reset", active_line_ref, 1'b0);
		check("sda drive in reset", sda_oe_n, 1'b1);
		check("sda drive value", sda_out, 1'b0);
	endtask

	task t_straps;
		check("strap zone", zone, zone_def);
		check("strap power down", power_down, 1'b0);
	endtask

	task t_address;
		host.write_reg(ADDR_AS_HIGH, IDX_ZONE, 8'h07, ack);
		check("ack select high", ack, 1'b1);
		check("zone written", zone, 4'h7);
		host.read_reg(ADDR_AS_HIGH, IDX_ZONE, rd);
		check("zone read back", rd, 8'h07);
		host.read_reg(ADDR_AS_HIGH, 8'h10, rd);
		check("unmapped read", rd, 8'h00);
		addr_sel = 1'b0;
		wait_clk(8);
		host.write_reg(ADDR_AS_HIGH, IDX_ZONE, 8'h03, ack);
		check("foreign address ack", ack, 1'b0);
		check("zone kept", zone, 4'h7);
		host.write_reg(ADDR_AS_LOW, IDX_ZONE, 8'h03, ack);
		check("ack select low", ack, 1'b1);
		check("zone second address", zone, 4'h3);
	endtask

	task t_chip_reset;
		chip_reset_n = 1'b0;
		wait_clk(10);
		check("zone chip reset", zone, zone_def);
		check("active_line_ref chip reset", active_line_ref, 1'b0);
		check("sda idle chip reset", sda, 1'b1);
		chip_reset_n = 1'b1;
		wait_clk(8);
	endtask

	task t_sync;
		wait_clk(20);
		check("vsync first line", vsync_n, 1'b0);
		check("hsync line start", hsync_n, 1'b1);
		check("active_line_ref sync lines", active_line_ref, 1'b0);
		host.write_reg(ADDR_AS_LOW, IDX_MODE, 8'h41, ack);
		check("vsync inverted", vsync_n, 1'b1);
		host.write_reg(ADDR_AS_LOW, IDX_MODE, 8'h21, ack);
		check("vsync restored", vsync_n, 1'b0);
		check("hsync inverted idle", hsync_n, 1'b0);
		host.write_reg(ADDR_AS_LOW, IDX_MODE, 8'h01, ack);
		adc_over = 1'b1;
		wait_clk(40);
		check("over range high", adc_over_range, 1'b1);
		adc_over = 1'b0;
		wait_clk(40);
		check("over range low", adc_over_range, 1'b0);
		host.hs_cnt = 0;
		for (int i = 0; i < 20000 && hsync_n !== 1'b0; i++)
			wait_clk(1);
		for (int i = 0; i < 2000 && hsync_n !== 1'b1; i++)
			wait_clk(1);
		wait_clk(40);
		check("hsync width", host.hs_cnt, 32'(H_SYNC_WORDS));
	endtask

	task t_pixel;
		@(posedge ref_clk);
		host.pclk_cnt = 0;
		repeat (100) @(posedge ref_clk);
		check("pixel clocks per ticks", host.pclk_cnt, 32'd100);
	endtask

	task t_power;
		wait_clk(1);
		pd_pin_n = 1'b0;
		wait_clk(10);
		check("pin power down", power_down, 1'b1);
		check("luma power down", luma, 8'h00);
		check("active_line_ref power down", active_line_ref, 1'b0);
		check("vsync power down", vsync_n, 1'b1);
		pd_pin_n = 1'b1;
		wait_clk(10);
		check("pin released", power_down, 1'b0);
		host.write_reg(ADDR_AS_LOW, IDX_MODE, 8'h11, ack);
		check("bit power down", power_down, 1'b1);
		host.write_reg(ADDR_AS_LOW, IDX_MODE, 8'h01, ack);
		check("bit released", power_down, 1'b0);
	endtask

	initial
	begin
		// about 60000 cycles, well past the longest path through the scenarios
		#240000;
		n_mismatch++;
		end_sim();
	end

	initial
	begin
		clk = 1'b0;
		resetn = 1'b0;
		chip_reset_n = 1'b1;
		pd_pin_n = 1'b1;
		addr_sel = 1'b1;
		strap = 7'h35;
		adc_data = 8'h5a;
		adc_over = 1'b0;
		n_mismatch = 0;
		n_checks = 0;
		wait_clk(8);
		t_reset();
		wait_clk(8);
		resetn = 1'b1;
		wait_clk(10);
		t_straps();
		t_address();
		t_chip_reset();
		t_sync();
		t_pixel();
		t_power();
		end_sim();
	end
endmodule

/* tb/video_host.sv */
// two-wire bus host and video capture model facing the camera port
`timescale 1ns/1ps
module video_host (
	// bus timing clock
	input wire logic clk,
	// two-wire bus, data line pulled up outside
	output logic scl,
	output logic sda_low,
	input wire logic sda,
	// video capture
	input wire logic pclk,
	input wire logic hsync_n
);
	int pclk_cnt;
	int hs_cnt;

	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
		pclk_cnt = 0;
		hs_cnt = 0;
	end

	// rising pixel clocks counted, and those seen with hsync low
	always @(posedge pclk)
	begin
		pclk_cnt <= pclk_cnt + 1;
		if (hsync_n === 1'b0)
			hs_cnt <= hs_cnt + 1;
	end

	task wait_clk(input int n);
		repeat (n) @(negedge clk);
	endtask

	// also serves as repeated start
	task start_cond;
		wait_clk(6);
		sda_low = 1'b0;
		wait_clk(12);
		scl = 1'b1;
		wait_clk(12);
		sda_low = 1'b1;
		wait_clk(12);
		scl = 1'b0;
	endtask

	task stop_cond;
		wait_clk(6);
		sda_low = 1'b1;
		wait_clk(12);
		scl = 1'b1;
		wait_clk(12);
		sda_low = 1'b0;
		wait_clk(12);
	endtask

	// data changes only while clock low; sampled mid-high
	task bit_out(input logic b, output logic s);
		wait_clk(6);
		sda_low = ~b;
		wait_clk(12);
		scl = 1'b1;
		wait_clk(6);
		s = sda;
		wait_clk(6);
		scl = 1'b0;
	endtask

	task byte_out(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_out(v[i], s);
		bit_out(1'b1, s);
		ack = ~s;
	endtask

	task byte_in(input logic last, output logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_out(1'b1, s);
			v[i] = s;
		end
		bit_out(last, s);
	endtask

	task write_reg(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d,
		output logic ack);
		logic k;
		start_cond();
		byte_out({a, 1'b0}, ack);
		if (ack)
		begin
			byte_out(idx, k);
			byte_out(d, k);
		end
		stop_cond();
	endtask

	task read_reg(input logic [6:0] a, input logic [7:0] idx, output logic [7:0] d);
		logic k;
		start_cond();
		byte_out({a, 1'b0}, k);
		byte_out(idx, k);
		start_cond();
		byte_out({a, 1'b1}, k);
		byte_in(1'b1, d);
		stop_cond();
	endtask
endmodule
